/* shared/selector_regs.svh */
`ifndef SELECTOR_REGS_SVH
`define SELECTOR_REGS_SVH

// register byte offsets
`define REG_CTRL 5'h00
`define REG_TIMEOUT 5'h04
`define REG_STORE 5'h08
`define REG_STATUS 5'h0c
`define REG_EVENT 5'h10

// control register fields
`define CTRL_ENABLE 0
`define CTRL_RANGE_LO 1
`define CTRL_RANGE_HI 3
`define CTRL_STEP_ACK 4
`define CTRL_CODE_ACK 5
`define CTRL_PWR_LO 6
`define CTRL_PWR_HI 7
`define CTRL_EVENTS 8
`define CTRL_RESET 32'h0000000e

// status register fields
`define STAT_ACTIVE_LO 0
`define STAT_PRESEL_LO 3
`define STAT_STEP_ALARM 6
`define STAT_CODE_ALARM 7
`define STAT_PWR_ALARM 8
`define STAT_STEP_BUSY 9
`define STAT_CODE_BUSY 10

// event register fields
`define EVT_POS_LO 0
`define EVT_KIND_LO 4
`define EVT_PENDING 8

// reset values
`define TIMEOUT_RESET_MS 16'h1388
`define STORE_RESET 3'h0

// timing
`define CLK_NS 40
`define TICK_NS 1000000
`define TICK_CYCLES ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define ALARM_S 3
`define ALARM_MS (`ALARM_S * 1000)
`define STEP_GAP_MS 50
`define POWER_CYCLE_MS 20
`define SYNC_MS (2 * `POWER_CYCLE_MS)

`endif

/* shared/selector_pkg.sv */
package selector_pkg;

  // power-up behaviour
  typedef enum logic [1:0] {
    pwr_restore,
    pwr_sync,
    pwr_sync_restore
  } power_mode_e;

  // sequencer states
  typedef enum logic [2:0] {
    st_off,
    st_wait,
    st_idle,
    st_step,
    st_code
  } state_e;

  // event kinds reported on the event port
  typedef enum logic [1:0] {
    ev_position,
    ev_step_alarm,
    ev_code_alarm
  } event_kind_e;

endpackage

/* logic/input_sync.sv */
module input_sync
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // raw and synchronised inputs
  input wire logic [5:0] async_in,
  output logic [5:0] sync_out
);

  logic [5:0] stage1;

  // two flip-flops per input bit
  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_bit
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* logic/position_selector_switch.sv */
`include "selector_regs.svh"

module position_selector_switch
  import selector_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register bus
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // control inputs
  input wire logic code_word_bit0,
  input wire logic code_word_bit1,
  input wire logic code_word_bit2,
  input wire logic code_path_confirm,
  input wire logic advance_request,
  input wire logic advance_confirm,
  // position outputs
  output logic [6:0] position_onehot,
  output logic [2:0] position_code,
  // alarms
  output logic advance_path_fault_flag,
  output logic code_path_fault_flag,
  output logic startup_fault_flag,
  // events
  output logic event_strobe,
  output logic [1:0] event_kind,
  output logic [2:0] event_position
);

  logic [31:0] ctrl;
  logic [15:0] timeout_ms;
  logic [2:0] store;
  logic [5:0] s_in;
  logic [5:0] in_prev;
  logic [31:0] presc;
  logic tick;
  logic [15:0] elapsed_ms;
  logic [5:0] gap_ms;
  logic [11:0] alarm_ms [2];
  logic [1:0] alarm_on;
  state_e state;
  state_e next_state;
  logic [2:0] preselect;
  logic [2:0] next_preselect;
  logic do_apply;
  logic [2:0] apply_pos;
  logic restart;
  logic step_taken;
  logic step_fail;
  logic code_fail;
  logic code_bad;
  logic pwr_fault_set;
  logic evt_pending;
  logic [1:0] evt_kind;
  logic [2:0] evt_pos;
  logic evt_fire;
  event_kind_e evt_kind_now;

  // configuration fields
  logic enable;
  logic [2:0] full_range;
  logic step_ack_mode;
  logic code_ack_mode;
  power_mode_e pwr_mode;
  logic events_on;
  assign enable = ctrl[`CTRL_ENABLE];
  assign full_range = ctrl[`CTRL_RANGE_HI:`CTRL_RANGE_LO];
  assign step_ack_mode = ctrl[`CTRL_STEP_ACK];
  assign code_ack_mode = ctrl[`CTRL_CODE_ACK];
  assign pwr_mode = power_mode_e'(ctrl[`CTRL_PWR_HI:`CTRL_PWR_LO]);
  assign events_on = ctrl[`CTRL_EVENTS];

  // position valid for the configured range; zero is rest
  function automatic logic in_range(input logic [2:0] pos, input logic [2:0] range);
    in_range = (pos != 3'h0) && (pos <= range);
  endfunction

  // next step-up position with wrap to 1
  function automatic logic [2:0] advance(input logic [2:0] pos, input logic [2:0] range);
    advance = ((pos >= range) || (pos == 3'h0)) ? 3'h1 : 3'(pos + 3'h1);
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = val[b*8 +: 8];
    end
    merge = res;
  endfunction

  // synchronise the asynchronous control inputs
  input_sync u_sync
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in({code_path_confirm, advance_confirm, advance_request,
               code_word_bit2, code_word_bit1, code_word_bit0}),
    .sync_out(s_in)
  );

  // code word, bit2 most significant
  logic [2:0] code;
  logic code_moved;
  logic step_rise;
  logic step_ack_rise;
  logic code_ack_rise;
  logic gap_ok;
  logic timed_out;
  assign code = s_in[2:0];
  assign code_moved = (s_in[2:0] != in_prev[2:0]);
  assign step_rise = s_in[3] & ~in_prev[3];
  assign step_ack_rise = s_in[4] & ~in_prev[4];
  assign code_ack_rise = s_in[5] & ~in_prev[5];
  assign gap_ok = (gap_ms >= 6'(`STEP_GAP_MS));
  assign timed_out = (elapsed_ms >= timeout_ms);

  // previous input values for edge and change detection
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      in_prev <= 6'h00;
    else
      in_prev <= s_in;
  end

  // millisecond tick from the system clock
  always_ff @(posedge clk_sys)
  begin
    if (srst || tick)
      presc <= 32'h00000000;
    else
      presc <= presc + 32'h00000001;
  end
  assign tick = (presc == 32'(TICK_CYCLES - 1));

  // time-out timer, restarted by path activity
  always_ff @(posedge clk_sys)
  begin
    if (srst || restart)
      elapsed_ms <= 16'h0000;
    else if (tick && elapsed_ms != 16'hffff)
      elapsed_ms <= elapsed_ms + 16'h0001;
  end

  // spacing guard between accepted step pulses
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      gap_ms <= 6'(`STEP_GAP_MS);
    else if (step_taken)
      gap_ms <= 6'h00;
    else if (tick && !gap_ok)
      gap_ms <= gap_ms + 6'h01;
  end

  // sequencer decisions
  always_comb
  begin
    next_state = state;
    next_preselect = preselect;
    do_apply = 1'b0;
    apply_pos = preselect;
    restart = 1'b0;
    step_taken = 1'b0;
    step_fail = 1'b0;
    code_fail = 1'b0;
    code_bad = 1'b0;
    pwr_fault_set = 1'b0;
    if (!enable && state != st_off && state != st_wait)
      next_state = st_idle;
    else
    begin
      case (state)
        st_off:
        begin
          if (enable)
          begin
            restart = 1'b1;
            if (pwr_mode == pwr_restore)
            begin
              next_state = st_idle;
              do_apply = 1'b1;
              if (in_range(store, full_range))
                apply_pos = store;
              else
              begin
                apply_pos = 3'h0;
                pwr_fault_set = 1'b1;
              end
            end
            else
            begin
              next_state = st_wait;
              pwr_fault_set = 1'b1;
            end
          end
        end
        st_wait:
        begin
          if (elapsed_ms >= 16'(`SYNC_MS))
          begin
            next_state = st_idle;
            do_apply = 1'b1;
            if (in_range(code, full_range))
              apply_pos = code;
            else if (pwr_mode == pwr_sync_restore && in_range(store, full_range))
              apply_pos = store;
            else
            begin
              apply_pos = 3'h0;
              pwr_fault_set = 1'b1;
            end
          end
          else
            pwr_fault_set = 1'b1;
        end
        st_idle:
        begin
          if (step_rise && gap_ok)
          begin
            step_taken = 1'b1;
            restart = 1'b1;
            next_preselect = advance(position_code, full_range);
            next_state = st_step;
          end
          else if (code_moved && code != 3'h0)
          begin
            if (in_range(code, full_range))
            begin
              next_preselect = code;
              restart = 1'b1;
              next_state = st_code;
            end
            else
              code_bad = 1'b1;
          end
        end
        st_step:
        begin
          // code inputs are not looked at here
          if (step_rise && gap_ok)
          begin
            step_taken = 1'b1;
            restart = 1'b1;
            next_preselect = advance(preselect, full_range);
          end
          else if (step_ack_mode && step_ack_rise)
          begin
            do_apply = 1'b1;
            next_state = st_idle;
          end
          else if (timed_out)
          begin
            next_state = st_idle;
            do_apply = !step_ack_mode;
            step_fail = step_ack_mode;
          end
        end
        st_code:
        begin
          // step pulses are not looked at here
          if (code_moved && code != 3'h0)
          begin
            if (in_range(code, full_range))
            begin
              next_preselect = code;
              restart = 1'b1;
            end
            else
              code_bad = 1'b1;
          end
          else if (code_ack_mode && code_ack_rise)
          begin
            do_apply = 1'b1;
            next_state = st_idle;
          end
          else if (timed_out)
          begin
            next_state = st_idle;
            do_apply = !code_ack_mode;
            code_fail = code_ack_mode;
          end
        end
        default:
          next_state = st_off;
      endcase
    end
  end

  // sequencer state and pre-selection
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= st_off;
      preselect <= 3'h0;
    end
    else
    begin
      state <= next_state;
      preselect <= (step_fail || code_fail) ? position_code : next_preselect;
    end
  end

  // applied position, both encodings, and the stored copy
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      position_code <= 3'h0;
      position_onehot <= 7'h00;
      store <= `STORE_RESET;
    end
    else
    begin
      if (do_apply)
      begin
        position_code <= apply_pos;
        position_onehot <= (apply_pos == 3'h0) ? 7'h00 : 7'(7'h01 << (apply_pos - 3'h1));
      end
      if (do_apply && apply_pos != 3'h0)
        store <= apply_pos;
      else if (write && !waitrequest && address == `REG_STORE && byteenable[0])
        store <= writedata[2:0];
    end
  end

  // three-second alarm timers for the step and code paths
  assign alarm_on = {code_fail | code_bad, step_fail};
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      advance_path_fault_flag <= 1'b0;
      code_path_fault_flag <= 1'b0;
      alarm_ms[0] <= 12'h000;
      alarm_ms[1] <= 12'h000;
    end
    else
    begin
      for (int a = 0; a < 2; a++)
      begin
        if (alarm_on[a])
          alarm_ms[a] <= 12'(`ALARM_MS);
        else if (tick && alarm_ms[a] != 12'h000)
          alarm_ms[a] <= alarm_ms[a] - 12'h001;
      end
      advance_path_fault_flag <= alarm_on[0] || (alarm_ms[0] > 12'h001) ||
                                 (alarm_ms[0] == 12'h001 && !tick);
      code_path_fault_flag <= alarm_on[1] || (alarm_ms[1] > 12'h001) ||
                              (alarm_ms[1] == 12'h001 && !tick);
    end
  end

  // startup alarm: held until a real position is applied
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      startup_fault_flag <= 1'b0;
    else if (pwr_fault_set)
      startup_fault_flag <= 1'b1;
    else if (do_apply && apply_pos != 3'h0)
      startup_fault_flag <= 1'b0;
  end

  // event port and sticky copy for software
  assign evt_fire = events_on && ((do_apply && apply_pos != position_code) ||
                                  step_fail || code_fail);
  assign evt_kind_now = step_fail ? ev_step_alarm : (code_fail ? ev_code_alarm : ev_position);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      event_strobe <= 1'b0;
      event_kind <= 2'h0;
      event_position <= 3'h0;
      evt_pending <= 1'b0;
      evt_kind <= 2'h0;
      evt_pos <= 3'h0;
    end
    else
    begin
      event_strobe <= evt_fire;
      if (evt_fire)
      begin
        event_kind <= evt_kind_now;
        event_position <= (step_fail || code_fail) ? preselect : apply_pos;
        evt_kind <= evt_kind_now;
        evt_pos <= (step_fail || code_fail) ? preselect : apply_pos;
        evt_pending <= 1'b1;
      end
      else if (read && !waitrequest && address == `REG_EVENT)
        evt_pending <= 1'b0;
    end
  end

  // bus slave: one wait cycle, then the access completes
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      ctrl <= `CTRL_RESET;
      timeout_ms <= `TIMEOUT_RESET_MS;
    end
    else
    begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest)
      begin
        case (address)
          `REG_CTRL: readdata <= ctrl;
          `REG_TIMEOUT: readdata <= {16'h0000, timeout_ms};
          `REG_STORE: readdata <= {29'h00000000, store};
          `REG_STATUS: readdata <= {21'h000000, state == st_code, state == st_step,
                                    startup_fault_flag, code_path_fault_flag,
                                    advance_path_fault_flag, preselect, position_code};
          `REG_EVENT: readdata <= {23'h000000, evt_pending, 2'h0, evt_kind, 1'b0, evt_pos};
          default: readdata <= 32'h00000000;
        endcase
      end
      if (write && !waitrequest && address == `REG_CTRL)
        ctrl <= merge(ctrl, writedata, byteenable) & 32'h000001ff;
      if (write && !waitrequest && address == `REG_TIMEOUT)
        timeout_ms <= 16'(merge({16'h0000, timeout_ms}, writedata, byteenable));
    end
  end

endmodule

/* testbench/position_selector_switch_properties.sv */
module position_selector_switch_properties
#(
  parameter int unsigned TICK_CYCLES = 10
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // outputs under watch
  input wire logic [6:0] position_onehot,
  input wire logic [2:0] position_code,
  input wire logic advance_path_fault_flag,
  input wire logic code_path_fault_flag,
  input wire logic event_strobe,
  input wire logic [1:0] event_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  localparam int ALARM_CYC = 3000 * TICK_CYCLES;
  int code_cnt;
  int step_cnt;
  // clocks each alarm has been standing
  always_ff @(posedge clk_sys)
  begin
    code_cnt <= (srst || !code_path_fault_flag) ? 0 : code_cnt + 1;
    step_cnt <= (srst || !advance_path_fault_flag) ? 0 : step_cnt + 1;
  end
  AST_ONEHOT_MATCH: assert property (position_onehot == ((position_code == 3'h0) ? 7'h00 :
    (7'h01 << (position_code - 3'h1)))) else $error("one-hot does not match code");
  AST_EVENT_PULSE: assert property (event_strobe |=> !event_strobe)
    else $error("event strobe longer than one clock");
  AST_EVENT_KIND: assert property (event_strobe |-> event_kind != 2'h3)
    else $error("event kind unknown");
  AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one clock");
  AST_READ_HOLD: assert property (!read && waitrequest |=> $stable(readdata))
    else $error("read data moved without a read");
  AST_CODE_ALARM_MIN: assert property ($rose(code_path_fault_flag) |-> code_path_fault_flag[*8])
    else $error("code alarm too short");
  AST_CODE_ALARM_END: assert property ($fell(code_path_fault_flag) && !$past(srst) |->
    $past(code_cnt) >= ALARM_CYC - TICK_CYCLES - 2) else $error("code alarm ended early");
  AST_CODE_ALARM_MAX: assert property (code_cnt <= ALARM_CYC + TICK_CYCLES + 2)
    else $error("code alarm too long");
  AST_STEP_ALARM_MAX: assert property (step_cnt <= ALARM_CYC + TICK_CYCLES + 2)
    else $error("step alarm too long");
  // main scenarios reached
  cover property (event_strobe && event_kind == 2'h0);
  cover property ($rose(code_path_fault_flag));
  cover property (read && !waitrequest);
endmodule

/* testbench/control_source.sv */
module control_source
(
  // clock
  input wire logic clk_sys,
  // drive toward the selector
  output logic [2:0] code_word,
  output logic advance_request,
  output logic advance_confirm,
  output logic code_path_confirm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pulses;
  // separate lines: 0 step, 1 step confirm, 2 code confirm
  assign advance_request = pulses[0];
  assign advance_confirm = pulses[1];
  assign code_path_confirm = pulses[2];
  // quiet levels, set while reset is still held
  task idle;
    code_word <= 3'h0;
    pulses <= 3'h0;
  endtask
  // new code word, taken as one unit
  task set_code(input logic [2:0] w);
    @(posedge clk_sys);
    code_word <= w;
  endtask
  // five clocks high so the synchroniser surely sees it
  task pulse(input int k);
    @(posedge clk_sys);
    pulses[k] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    pulses[k] <= 1'b0;
  endtask
endmodule

/* testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata, q;
  logic waitrequest, cpc, adv, advc, ast, acf, ccf, ev;
  logic [2:0] cw, pos, evp, ev_pos;
  logic [6:0] oh;
  logic [1:0] evk, ev_kind;
  int n_fail = 0;
  int total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  control_source src (.clk_sys(clk_sys), .code_word(cw), .advance_request(adv),
    .advance_confirm(advc), .code_path_confirm(cpc));
  position_selector_switch #(.TICK_CYCLES(TICK)) DUT (.clk_sys(clk_sys), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .code_word_bit0(cw[0]), .code_word_bit1(cw[1]), .code_word_bit2(cw[2]),
    .code_path_confirm(cpc), .advance_request(adv), .advance_confirm(advc),
    .position_onehot(oh), .position_code(pos), .advance_path_fault_flag(acf),
    .code_path_fault_flag(ccf), .startup_fault_flag(ast), .event_strobe(ev),
    .event_kind(evk), .event_position(evp));
  // latest event seen
  always @(negedge clk_sys)
  begin
    if (ev === 1'b1)
    begin
      ev_kind <= evk;
      ev_pos <= evp;
    end
  end
  task print_verdict;
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_out(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask
  task give_up;
    n_fail++;
    print_verdict();
  endtask
  // one bus access, held until waitrequest is seen low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin @(posedge clk_sys); n++; end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) give_up();
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task wait_pos(input logic [2:0] exp, input int bound);
    int n;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (pos !== exp && n < bound);
    if (n >= bound) give_up();
    chk_out({5'h0, pos}, {5'h0, exp});
    chk_out({1'b0, oh}, (exp == 3'h0) ? 8'h00 : (8'h01 << (exp - 3'h1)));
  endtask
  task t_reset_values;
    bus(1'b0, 5'h00, 32'h0); chk_reg(q, 32'h0000000e);
    bus(1'b0, 5'h04, 32'h0); chk_reg(q, 32'h00001388);
    bus(1'b0, 5'h08, 32'h0); chk_reg(q, 32'h0);
    bus(1'b0, 5'h14, 32'h0); chk_reg(q, 32'h0);
    chk_out({5'h0, pos}, 8'h00);
  endtask
  task t_restore;
    byteenable <= 4'h1;
    bus(1'b1, 5'h04, 32'hffffff3c);
    byteenable <= 4'hf;
    bus(1'b0, 5'h04, 32'h0);
    chk_reg(q, 32'h0000133c);
    bus(1'b1, 5'h04, 32'd60);
    bus(1'b1, 5'h08, 32'h5);
    bus(1'b1, 5'h00, 32'h10f);
    wait_pos(3'h5, 200);
    chk_out({7'h0, ast}, 8'h00);
  endtask
  task t_code_timeout;
    src.set_code(3'h3);
    repeat (300) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h05);
    wait_pos(3'h3, 600);
    @(negedge clk_sys);
    chk_out({6'h0, ev_kind}, 8'h00);
    chk_out({5'h0, ev_pos}, 8'h03);
    src.set_code(3'h0);
    repeat (1000) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h03);
  endtask
  task t_step_wrap;
    bus(1'b1, 5'h00, 32'h109);
    src.pulse(0);
    src.set_code(3'h2);
    repeat (520) @(posedge clk_sys);
    src.pulse(0);
    repeat (100) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h03);
    wait_pos(3'h1, 700);
    repeat (700) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h01);
  endtask
  task t_code_ack;
    bus(1'b1, 5'h00, 32'h129);
    src.set_code(3'h4);
    src.pulse(1);
    repeat (50) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h01);
    src.pulse(2);
    wait_pos(3'h4, 50);
  endtask
  task t_code_missed;
    int n;
    n = 0;
    src.set_code(3'h3);
    do begin @(negedge clk_sys); n++; end while (ccf !== 1'b1 && n < 800);
    if (n >= 800) give_up();
    @(negedge clk_sys);
    chk_out({6'h0, ev_kind}, 8'h02);
    chk_out({5'h0, ev_pos}, 8'h03);
    chk_out({5'h0, pos}, 8'h04);
    n = 0;
    do begin @(negedge clk_sys); n++; end while (ccf === 1'b1 && n < 31000);
    chk_out({7'h0, n >= 3000 * TICK - TICK - 10 && n <= 3000 * TICK + TICK}, 8'h01);
  endtask
  // step path with confirm, then a step left unconfirmed, then a code out of range
  task t_step_ack;
    int n;
    n = 0;
    bus(1'b1, 5'h00, 32'h119);
    src.pulse(0);
    src.pulse(2);
    repeat (20) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h04);
    src.pulse(1);
    wait_pos(3'h1, 50);
    repeat (520) @(posedge clk_sys);
    src.pulse(0);
    do begin @(negedge clk_sys); n++; end while (acf !== 1'b1 && n < 800);
    if (n >= 800) give_up();
    @(negedge clk_sys);
    chk_out({6'h0, ev_kind}, 8'h01);
    chk_out({5'h0, ev_pos}, 8'h02);
    chk_out({5'h0, pos}, 8'h01);
    bus(1'b0, 5'h0c, 32'h0);
    chk_reg(q, 32'h00000049);
    bus(1'b0, 5'h10, 32'h0);
    chk_reg(q, 32'h00000112);
    bus(1'b0, 5'h10, 32'h0);
    chk_reg(q, 32'h00000012);
    src.set_code(3'h6);
    repeat (10) @(negedge clk_sys);
    chk_out({6'h0, ccf, acf}, 8'h03);
    chk_out({5'h0, pos}, 8'h01);
  endtask
  // reset in mid-run; outputs must be quiet at the first edges after release
  task reboot;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_out({5'h0, pos}, 8'h00);
    chk_out({5'h0, acf, ccf, ast}, 8'h00);
  endtask
  // power-up in sync mode, failed sync, and sync falling back to the store
  task t_power_up;
    reboot();
    src.set_code(3'h3);
    bus(1'b1, 5'h00, 32'h4f);
    repeat (200) @(negedge clk_sys);
    chk_out({4'h0, ast, pos}, 8'h08);
    wait_pos(3'h3, 400);
    chk_out({7'h0, ast}, 8'h00);
    reboot();
    src.set_code(3'h0);
    bus(1'b1, 5'h00, 32'h4f);
    repeat (600) @(negedge clk_sys);
    chk_out({4'h0, ast, pos}, 8'h08);
    reboot();
    bus(1'b1, 5'h08, 32'h2);
    bus(1'b1, 5'h00, 32'h8f);
    wait_pos(3'h2, 600);
    chk_out({7'h0, ast}, 8'h00);
  endtask
  initial
  begin
    @(posedge clk_sys);
    address <= 5'h00;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= 32'h0;
    byteenable <= 4'hf;
    src.idle();
    @(posedge clk_sys);
    srst <= 1'b0;
    t_reset_values();
    t_restore();
    t_code_timeout();
    t_step_wrap();
    t_code_ack();
    t_code_missed();
    t_step_ack();
    t_power_up();
    print_verdict();
  end
endmodule

bind position_selector_switch position_selector_switch_properties #(.TICK_CYCLES(TICK_CYCLES))
  u_props (.clk_sys(clk_sys), .srst(srst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .position_onehot(position_onehot),
  .position_code(position_code), .advance_path_fault_flag(advance_path_fault_flag),
  .code_path_fault_flag(code_path_fault_flag), .event_strobe(event_strobe),
  .event_kind(event_kind));
